/* File: rtl/bndm_memory.sv */
// Banked nibble data memory with shared system registers and mapped peripheral windows
`timescale 1ns/1ns
// ---------------------------------------------------------------------------
// ---------------------------------------------------------------------------
module bndm_memory
  import bndm_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Instruction access
  input bndm_req_t req,
  output bndm_rsp_t rsp,
  // System register views
  output logic [15:0] program_address_register,
  output logic [3:0] register_file_window,
  output logic [3:0] bank_selector,
  output logic [11:0] index_row_pointer,
  output logic [7:0] general_register_pointer,
  output logic [3:0] program_status_word,
  // Mapped peripheral storage views
  output logic [15:0] transfer_buffer,
  output logic [15:0] port_data,
  output logic [63:0] port_direction
);
  import bndm_pkg::*;

  // ---------------------------------------------------------------------------
  // Address formation
  // ---------------------------------------------------------------------------
  bndm_addr_t addr;
  bndm_target_t target;
  logic [3:0] sys_reg [BNDM_SYS_COUNT];
  logic [3:0] buf_reg [BNDM_BUF_COUNT];
  logic [3:0] port_reg [BNDM_PORT_COUNT];
  logic [3:0] dir_reg [BNDM_DIR_COUNT];
  // Not reset: contents are left undefined at power on
  logic [3:0] gp_mem [BNDM_GP_WORDS];
  logic [3:0] sys_idx;
  logic wr_sys, wr_buf, wr_port, wr_dir, wr_gp;
  logic [3:0] next_rdata;

  // Bank from the selector, row and column direct from the operand
  bndm_decode u_decode (
    .bank(bank_selector),
    .row(req.row),
    .col(req.col),
    .addr(addr),
    .target(target)
  );

  assign sys_idx = addr.loc[3:0] - BNDM_SYS_FIRST[3:0];
  // Unpopulated targets get no strobe at all
  assign wr_sys = req.wr && (target == bndm_tgt_sys);
  assign wr_buf = req.wr && (target == bndm_tgt_buf);
  assign wr_port = req.wr && (target == bndm_tgt_port);
  assign wr_dir = req.wr && (target == bndm_tgt_dir);
  assign wr_gp = req.wr && (target == bndm_tgt_gp);

  // ---------------------------------------------------------------------------
  // Shared system registers
  // ---------------------------------------------------------------------------
  // Bank bits are ignored here, so every bank sees one set
  always_ff @(posedge clock) begin
    if (!resetn) begin
      for (int i = 0; i < BNDM_SYS_COUNT; i++) begin
        sys_reg[i] <= 4'h0;
      end
    end else if (wr_sys) begin
      sys_reg[sys_idx] <= req.wdata;
    end
  end

  // Registered views of the system register fields
  always_ff @(posedge clock) begin
    if (!resetn) begin
      program_address_register <= 16'h0000;
      register_file_window <= 4'h0;
      bank_selector <= 4'h0;
      index_row_pointer <= 12'h000;
      general_register_pointer <= 8'h00;
      program_status_word <= 4'h0;
    end else begin
      program_address_register <= {sys_reg[0], sys_reg[1], sys_reg[2], sys_reg[3]};
      register_file_window <= sys_reg[4];
      index_row_pointer <= {sys_reg[6], sys_reg[7], sys_reg[8]};
      general_register_pointer <= {sys_reg[9], sys_reg[10]};
      program_status_word <= sys_reg[11];
      // Bank change takes effect for the next instruction, one cycle before the other views follow a write
      bank_selector <= (wr_sys && sys_idx == BNDM_SYS_IDX_BANK) ? req.wdata : bank_selector;
    end
  end

  // ---------------------------------------------------------------------------
  // Transfer buffer, port and direction registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!resetn) begin
      for (int i = 0; i < BNDM_BUF_COUNT; i++) begin
        buf_reg[i] <= 4'h0;
      end
    end else if (wr_buf) begin
      buf_reg[addr.loc[1:0]] <= req.wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      for (int i = 0; i < BNDM_PORT_COUNT; i++) begin
        port_reg[i] <= 4'h0;
      end
    end else if (wr_port) begin
      port_reg[addr.loc[1:0]] <= req.wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      for (int i = 0; i < BNDM_DIR_COUNT; i++) begin
        dir_reg[i] <= 4'h0;
      end
    end else if (wr_dir) begin
      dir_reg[addr.loc[3:0]] <= req.wdata;
    end
  end

  genvar g;
  generate
    for (g = 0; g < BNDM_BUF_COUNT; g++) begin : g_buf_view
      always_ff @(posedge clock) begin
        if (!resetn) begin
          transfer_buffer[g*4 +: 4] <= 4'h0;
          port_data[g*4 +: 4] <= 4'h0;
        end else begin
          transfer_buffer[g*4 +: 4] <= buf_reg[g];
          port_data[g*4 +: 4] <= port_reg[g];
        end
      end
    end
    for (g = 0; g < BNDM_DIR_COUNT; g++) begin : g_dir_view
      always_ff @(posedge clock) begin
        if (!resetn) begin
          port_direction[g*4 +: 4] <= 4'h0;
        end else begin
          port_direction[g*4 +: 4] <= dir_reg[g];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // General-purpose storage
  // ---------------------------------------------------------------------------
  // Full image of all 16 banks at 128 words each; mapped and hole slots are simply never written,
  // which keeps indexing trivial at the cost of a few unused words
  always_ff @(posedge clock) begin
    if (wr_gp) begin
      gp_mem[{addr.bank, addr.loc}] <= req.wdata;
    end
  end

  // ---------------------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------------------
  // Storage is read in the request cycle and the answer is registered for the next, so a write in an earlier
  // cycle is already in storage
  always_comb begin
    next_rdata = 4'h0;
    unique case (target)
      bndm_tgt_gp: next_rdata = gp_mem[{addr.bank, addr.loc}];
      bndm_tgt_sys: next_rdata = sys_reg[sys_idx];
      bndm_tgt_buf: next_rdata = buf_reg[addr.loc[1:0]];
      bndm_tgt_port: next_rdata = port_reg[addr.loc[1:0]];
      bndm_tgt_dir: next_rdata = dir_reg[addr.loc[3:0]];
      // Holes read as zero; any value is allowed there
      bndm_tgt_none: next_rdata = 4'h0;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      rsp <= '0;
    end else begin
      rsp.valid <= req.rd;
      rsp.populated <= req.rd && (target != bndm_tgt_none);
      rsp.rdata <= req.rd ? next_rdata : 4'h0;
    end
  end
endmodule

/* File: rtl/bndm_pkg.sv */
// Package for the banked nibble data memory: address fields, map constants and carriers
package bndm_pkg;
  localparam int BNDM_NIB_W = 4;
  localparam int BNDM_BANK_W = 4;
  localparam int BNDM_ROW_W = 3;
  localparam int BNDM_COL_W = 4;
  localparam int BNDM_LOC_W = BNDM_ROW_W + BNDM_COL_W;
  localparam int BNDM_ADDR_W = BNDM_BANK_W + BNDM_LOC_W;
  localparam int BNDM_BANK_LOCS = 128;
  localparam int BNDM_NUM_BANKS = 16;
  localparam int BNDM_GP_WORDS = BNDM_NUM_BANKS * BNDM_BANK_LOCS;

  // Variant selection: large has all sixteen banks, small lacks banks 10 to 14
  localparam logic BNDM_VARIANT_LARGE = 1'b1;
  localparam logic [3:0] BNDM_SMALL_LAST_BANK = 4'h9;
  localparam logic [3:0] BNDM_TOP_BANK = 4'hF;
  localparam logic [3:0] BNDM_PORT_LAST_BANK = 4'h3;
  localparam logic [3:0] BNDM_BUF_BANK = 4'h0;

  // Location map inside a bank
  localparam logic [6:0] BNDM_SYS_FIRST = 7'h74;
  localparam logic [6:0] BNDM_SYS_LAST = 7'h7F;
  localparam logic [6:0] BNDM_PORT_FIRST = 7'h70;
  localparam logic [6:0] BNDM_PORT_LAST = 7'h73;
  localparam logic [6:0] BNDM_DIR_FIRST = 7'h60;
  localparam logic [6:0] BNDM_DIR_LAST = 7'h6F;
  localparam logic [6:0] BNDM_BUF_FIRST = 7'h0C;
  localparam logic [6:0] BNDM_BUF_LAST = 7'h0F;
  localparam logic [6:0] BNDM_HOLE_LAST = 7'h5F;

  // System register offsets
  localparam logic [6:0] BNDM_PROGRAM_ADDRESS_REGISTER = 7'h74;
  localparam logic [6:0] BNDM_REGISTER_FILE_WINDOW = 7'h78;
  localparam logic [6:0] BNDM_BANK_SELECTOR = 7'h79;
  localparam logic [6:0] BNDM_INDEX_ROW_POINTER = 7'h7A;
  localparam logic [6:0] BNDM_GENERAL_REGISTER_POINTER = 7'h7D;
  localparam logic [6:0] BNDM_PROGRAM_STATUS_WORD = 7'h7F;
  localparam int BNDM_SYS_COUNT = 12;
  localparam logic [3:0] BNDM_SYS_IDX_BANK = 4'h5;
  localparam int BNDM_BUF_COUNT = 4;
  localparam int BNDM_PORT_COUNT = 4;
  localparam int BNDM_DIR_COUNT = 16;

  typedef enum logic [2:0] {
    bndm_tgt_none,
    bndm_tgt_gp,
    bndm_tgt_sys,
    bndm_tgt_buf,
    bndm_tgt_port,
    bndm_tgt_dir
  } bndm_target_t;

  typedef struct packed {
    logic [3:0] bank;
    logic [6:0] loc;
  } bndm_addr_t;

  // One instruction access from the execution logic
  typedef struct packed {
    logic rd;
    logic wr;
    logic [2:0] row;
    logic [3:0] col;
    logic [3:0] wdata;
  } bndm_req_t;

  // Answer to the execution logic
  typedef struct packed {
    logic valid;
    logic populated;
    logic [3:0] rdata;
  } bndm_rsp_t;
endpackage

/* File: rtl/bndm_decode.sv */
// Address former and decoder for the banked nibble data memory
`timescale 1ns/1ns
module bndm_decode
  import bndm_pkg::*;
(
  // Inputs
  input wire logic [3:0] bank,
  input wire logic [2:0] row,
  input wire logic [3:0] col,
  // Decoded target
  output bndm_addr_t addr,
  output bndm_target_t target
);
  import bndm_pkg::*;

  function automatic logic bank_present(input logic [3:0] b);
    if (BNDM_VARIANT_LARGE) begin
      return 1'b1;
    end
    return (b <= BNDM_SMALL_LAST_BANK) || (b == BNDM_TOP_BANK);
  endfunction

  always_comb begin
    addr.bank = bank;
    addr.loc = {row, col};
    target = bndm_tgt_gp;
    if (addr.loc >= BNDM_SYS_FIRST) begin
      target = bndm_tgt_sys;
    end else if (!bank_present(bank)) begin
      target = bndm_tgt_none;
    end else if (addr.loc >= BNDM_PORT_FIRST) begin
      target = (bank <= BNDM_PORT_LAST_BANK) ? bndm_tgt_port : bndm_tgt_gp;
    end else if (bank == BNDM_TOP_BANK) begin
      target = (addr.loc >= BNDM_DIR_FIRST) ? bndm_tgt_dir : bndm_tgt_none;
    end else if (bank == BNDM_BUF_BANK && addr.loc >= BNDM_BUF_FIRST &&
                 addr.loc <= BNDM_BUF_LAST) begin
      target = bndm_tgt_buf;
    end
  end
endmodule

/* File: verif/bndm_memory_properties.sv */
// Concurrent checks on the ports of the banked nibble data memory
`timescale 1ns/1ns
module bndm_memory_properties
  import bndm_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Access and answer
  input bndm_pkg::bndm_req_t req,
  input bndm_pkg::bndm_rsp_t rsp,
  // Register views
  input wire logic [3:0] bank_selector,
  input wire logic [3:0] program_status_word,
  input wire logic [15:0] transfer_buffer,
  input wire logic [15:0] port_data,
  input wire logic [63:0] port_direction
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  wire [6:0] loc = {req.row, req.col};
  wire [1:0] sub = req.col[1:0];
  // ----
  // Read answer
  // ----
  sequence s_answer(logic pop);
    ##1 rsp.valid && rsp.populated == pop;
  endsequence
  chk_read_answer: assert property (req.rd |=> rsp.valid)
    else $error("read not answered");
  chk_idle_quiet: assert property (!req.rd |=> !rsp.valid)
    else $error("answer without read");
  chk_hole_empty: assert property (req.rd && bank_selector == 4'hF && loc < 7'h60
    |-> s_answer(1'b0)) else $error("hole read populated");
  chk_gp_populated: assert property (req.rd && bank_selector == 4'h1 && loc < 7'h70
    |-> s_answer(1'b1)) else $error("storage read empty");
  chk_sys_shared: assert property (req.rd && loc == 7'h7F
    |=> rsp.rdata == program_status_word) else $error("status read wrong");
  // ----
  // Mapped writes
  // ----
  chk_bank_update: assert property (req.wr && loc == 7'h79
    |=> bank_selector == $past(req.wdata)) else $error("bank not updated");
  chk_buf_write: assert property (req.wr && bank_selector == 4'h0 && loc[6:2] == 5'h03
    |-> ##2 transfer_buffer[4*$past(sub, 2) +: 4] == $past(req.wdata, 2))
    else $error("buffer write");
  chk_port_write: assert property (req.wr && bank_selector <= 4'h3 && loc[6:2] == 5'h1C
    |-> ##2 port_data[4*$past(sub, 2) +: 4] == $past(req.wdata, 2)) else $error("port write");
  chk_dir_write: assert property (req.wr && bank_selector == 4'hF && loc[6:4] == 3'h6
    |-> ##2 port_direction[4*$past(req.col, 2) +: 4] == $past(req.wdata, 2))
    else $error("dir write");
  chk_port_other: assert property (req.wr && bank_selector == 4'h5
    |-> ##2 $stable(port_data)) else $error("port changed from bank 5");
endmodule
bind bndm_memory bndm_memory_properties i_props (.clock(clock), .resetn(resetn), .req(req),
  .rsp(rsp), .bank_selector(bank_selector), .program_status_word(program_status_word),
  .transfer_buffer(transfer_buffer), .port_data(port_data), .port_direction(port_direction));

/* File: verif/bndm_cpu_model.sv */
// Instruction-side model that issues one data memory access per cycle
`timescale 1ns/1ns
module bndm_cpu_model
  import bndm_pkg::*;
(
  // Clock
  input wire logic clock,
  // Access towards the memory
  output bndm_pkg::bndm_req_t req
);
  initial req = '0;
  // Caller enters 1 ns after an edge; the request is held through the next edge
  task automatic op(input logic r, input logic w, input logic [6:0] a, input logic [3:0] v);
    req = {r, w, a, v};
    @(posedge clock);
    #1;
  endtask
endmodule

/* File: verif/bndm_memory_bench.sv */
// Self-checking bench for the banked nibble data memory
`timescale 1ns/1ns
module bndm_memory_bench;
  import bndm_pkg::*;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  bndm_req_t req;
  bndm_rsp_t rsp;
  logic [15:0] par, tbuf, pdat;
  logic [3:0] win, bsel, psw, d;
  logic [11:0] irp;
  logic [7:0] grp;
  logic [63:0] pdir;
  logic [6:0] loc;
  int n_errors = 0;
  int samples_checked = 0;
  int seed = 32'ha0ad;

  initial forever #5 clock = ~clock;
  bndm_cpu_model i_cpu (.clock(clock), .req(req));
  bndm_memory i_dut (.clock(clock), .resetn(resetn), .req(req), .rsp(rsp),
    .program_address_register(par), .register_file_window(win), .bank_selector(bsel),
    .index_row_pointer(irp), .general_register_pointer(grp), .program_status_word(psw),
    .transfer_buffer(tbuf), .port_data(pdat), .port_direction(pdir));

  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [3:0] v);
    i_cpu.op(1'b0, 1'b1, a, v);
  endtask
  // Hole reads come back as zero in this design
  task automatic rd(input logic [6:0] a, input logic p, input logic [3:0] v);
    i_cpu.op(1'b1, 1'b0, a, 4'h0);
    check("valid", 1'b1, rsp.valid);
    check("populated", p, rsp.populated);
    check("rdata", v, rsp.rdata);
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    #100000;
    n_errors++;
    finish_test();
  end

  initial begin
    repeat (8) @(posedge clock);
    #1 resetn = 1'b1;
    check("views", 64'h0, {16'h0000, par, win, bsel, irp, grp, psw});
    check("mapped", 64'h0, {32'h0000_0000, tbuf, pdat});
    check("dir_reset", 64'h0, pdir);
    // ----
    // Storage in every bank, written then read back at once
    // ----
    for (int b = 0; b < 16; b++) begin
      wr(7'h79, 4'(b));
      loc = {3'($unsigned($random(seed)) % 7), 4'($random(seed))};
      if (b == 15) loc = {5'h1C, loc[1:0]};
      d = 4'($random(seed));
      wr(loc, d);
      rd(loc, 1'b1, d);
    end
    wr(7'h25, ~d);
    rd(7'h25, 1'b0, 4'h0);
    rd(loc, 1'b1, d);
    // ----
    // Shared system registers and mapped windows
    // ----
    wr(7'h7F, 4'h6);
    for (int i = 0; i < 4; i++) wr(7'(116 + i), 4'(10 + i));
    wr(7'h79, 4'h3);
    rd(7'h7F, 1'b1, 4'h6);
    rd(7'h79, 1'b1, 4'h3);
    check("status", 4'h6, psw);
    check("address", 16'hABCD, par);
    wr(7'h79, 4'h0);
    for (int i = 0; i < 4; i++) wr(7'(12 + i), 4'(i + 1));
    wr(7'h79, 4'h2);
    for (int i = 0; i < 4; i++) wr(7'(112 + i), 4'(i + 5));
    wr(7'h79, 4'hF);
    for (int i = 0; i < 16; i++) wr(7'(96 + i), 4'(i));
    wr(7'h79, 4'h5);
    wr(7'h70, 4'h9);
    rd(7'h70, 1'b1, 4'h9);
    check("buffer", 16'h4321, tbuf);
    check("ports", 16'h8765, pdat);
    check("direction", 64'hFEDC_BA98_7654_3210, pdir);
    finish_test();
  end
endmodule
